//--- multichip_dac_sync_logic.sv
// Multichip sync: state machine alignment to the reference sync clock
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module multichip_dac_sync_logic (
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Sync pins and clocking strap
	input  wire logic       i_ref_sync_clock,
	input  wire logic       i_multiplier_used,
	// Status and phase outputs
	output logic            o_irq_req,
	output logic      [5:0] o_clk_state,
	output logic            o_fifo_rd_strobe
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] mode_ctrl_ff;
	logic [7:0] phase_req_ff;
	logic [1:0] irq_en_ff;
	logic       locked_ff;
	logic       lost_ff;
	logic       wr_ctrl;
	logic       wr_stat;
	logic       sync_on;
	logic       fifo_mode;
	logic [1:0] mult_meta_ff;

	// Clocking strap is a pin: two flops before use
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			mult_meta_ff <= 2'b00;
		else
			mult_meta_ff <= {mult_meta_ff[0], i_multiplier_used};
	end

	assign wr_ctrl = i_wr && (i_addr == sync_pkg::ADDR_MODE_CTRL);
	assign wr_stat = i_wr && (i_addr == sync_pkg::ADDR_LOCK_STAT);
	assign sync_on = mode_ctrl_ff[sync_pkg::CTRL_ENABLE_BIT];
	// FIFO-rate only with a direct sample clock
	assign fifo_mode = !mode_ctrl_ff[sync_pkg::CTRL_DATA_BIT] && !mult_meta_ff[1];

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			mode_ctrl_ff <= sync_pkg::MODE_CTRL_RST;
			phase_req_ff <= sync_pkg::PHASE_REQ_RST;
			irq_en_ff    <= sync_pkg::IRQ_ENABLE_RST[1:0];
		end else if (i_wr) begin
			if (wr_ctrl)
				mode_ctrl_ff <= i_wdata;
			if (i_addr == sync_pkg::ADDR_PHASE_REQ)
				phase_req_ff <= {2'b00, i_wdata[5:0]};
			if (i_addr == sync_pkg::ADDR_IRQ_ENABLE)
				irq_en_ff <= i_wdata[sync_pkg::STAT_LOST_BIT:sync_pkg::STAT_LOCK_BIT];
		end
	end

	// ------------------------------------------------------------
	// Reference sampling, rising or falling phase
	// ------------------------------------------------------------
	logic [1:0] ref_meta_ff;
	logic       ref_fall_ff;
	logic       ref_prev_ff;
	logic       ref_samp;
	logic       ref_edge;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			ref_meta_ff <= 2'b00;
		else
			ref_meta_ff <= {ref_meta_ff[0], i_ref_sync_clock};
	end

	// Falling-edge choice modelled as a one-cycle later sample
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ref_fall_ff <= 1'b0;
			ref_prev_ff <= 1'b0;
		end else begin
			ref_fall_ff <= ref_meta_ff[1];
			ref_prev_ff <= ref_samp;
		end
	end

	assign ref_samp = mode_ctrl_ff[sync_pkg::CTRL_EDGE_BIT] ? ref_meta_ff[1] : ref_fall_ff;
	assign ref_edge = ref_samp && !ref_prev_ff;

	// ------------------------------------------------------------
	// Clock-generation state machine, 64 states
	// ------------------------------------------------------------
	logic [5:0] state_ff;
	logic [2:0] div_ff;
	logic       do_resync;
	logic       fifo_tick;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			state_ff <= sync_pkg::PHASE_REQ_RST[5:0];
		else if (do_resync)
			state_ff <= 6'(phase_req_ff[5:0] + sync_pkg::RESYNC_LEAD);
		else
			state_ff <= 6'(state_ff + 6'h01);
	end

	// FIFO read pointer tick: one per eight states
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			div_ff <= 3'h0;
		else if (do_resync)
			div_ff <= 3'h0;
		else
			div_ff <= 3'(div_ff + 3'h1);
	end
	assign fifo_tick = (div_ff == 3'(sync_pkg::FIFO_DEPTH - 1));

	// ------------------------------------------------------------
	// Phase measurement and averaging
	// ------------------------------------------------------------
	logic [5:0]  meas_phase;
	logic [13:0] acc_ff;
	logic [7:0]  cnt_ff;
	logic [7:0]  avg_len;
	logic [2:0]  avg_code;
	logic [7:0]  avg_phase_ff;
	logic        avg_done;
	logic [13:0] acc_sum;
	logic [13:0] acc_shift;

	// Data-rate aligns to all 64 states, FIFO-rate to the coarser grid
	assign meas_phase = fifo_mode ? {state_ff[5:3], 3'b000} : state_ff;
	assign avg_code  = mode_ctrl_ff[2:0];
	assign avg_len   = 8'h01 << avg_code;
	assign avg_done  = ref_edge && (cnt_ff == 8'(avg_len - 8'h01));
	assign acc_sum   = 14'(acc_ff + {8'h00, meas_phase});
	// Mean in 6.2: scale by four, then shift by k
	assign acc_shift = 14'(({2'b00, acc_sum} << 2) >> avg_code);

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !sync_on) begin
			acc_ff       <= 14'h0000;
			cnt_ff       <= 8'h00;
			avg_phase_ff <= 8'h00;
		end else if (avg_done) begin
			acc_ff       <= 14'h0000;
			cnt_ff       <= 8'h00;
			avg_phase_ff <= (avg_code == 3'h0) ? {acc_sum[5:0], 2'b00} : acc_shift[7:0];
		end else if (ref_edge) begin
			acc_ff <= acc_sum;
			cnt_ff <= 8'(cnt_ff + 8'h01);
		end
	end

	// ------------------------------------------------------------
	// Lock tracking
	// ------------------------------------------------------------
	logic [7:0]  last_phase_ff;
	logic [7:0]  stable_ff;
	logic [7:0]  lock_need;
	logic        avg_valid_ff;
	logic [7:0]  target;
	logic [5:0]  err;
	logic        big_err;

	// FIFO-rate compares on the same coarse grid as the measurement
	assign target  = {fifo_mode ? {phase_req_ff[5:3], 3'b000} : phase_req_ff[5:0], 2'b00};
	assign lock_need = 8'(8'(sync_pkg::LOCK_BASE) + avg_len);
	assign err     = 6'(avg_phase_ff[7:2] - target[7:2]);
	assign big_err = (err > {3'b000, sync_pkg::PHASE_THRESHOLD}) &&
			(err < 6'(sync_pkg::NUM_STATES - 1));
	assign do_resync = sync_on && avg_valid_ff && big_err;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !sync_on)
			avg_valid_ff <= 1'b0;
		else
			avg_valid_ff <= avg_done;
	end

	// Constant phase for eleven plus averaging reference periods means locked
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !sync_on) begin
			stable_ff     <= 8'h00;
			last_phase_ff <= 8'h00;
		end else begin
			if (avg_valid_ff)
				last_phase_ff <= avg_phase_ff;
			if (do_resync || (avg_valid_ff && avg_phase_ff != last_phase_ff))
				stable_ff <= 8'h00;
			else if (ref_edge && stable_ff != 8'hff)
				stable_ff <= 8'(stable_ff + 8'h01);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !sync_on)
			locked_ff <= 1'b0;
		else
			locked_ff <= (stable_ff >= lock_need) && !do_resync;
	end

	// Set wins over a software overwrite in the same cycle
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			lost_ff <= 1'b0;
		else if (locked_ff && do_resync)
			lost_ff <= 1'b1;
		else if (wr_stat)
			lost_ff <= i_wdata[sync_pkg::STAT_LOST_BIT];
	end

	// ------------------------------------------------------------
	// Outputs and read port
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_irq_req        <= 1'b0;
			o_clk_state      <= 6'h00;
			o_fifo_rd_strobe <= 1'b0;
		end else begin
			o_irq_req        <= (irq_en_ff[1] && lost_ff) || (irq_en_ff[0] && locked_ff);
			o_clk_state      <= state_ff;
			o_fifo_rd_strobe <= fifo_tick;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			o_rdata <= 8'h00;
		else if (i_rd) begin
			unique case (i_addr)
				sync_pkg::ADDR_MODE_CTRL:  o_rdata <= mode_ctrl_ff;
				sync_pkg::ADDR_PHASE_REQ:  o_rdata <= phase_req_ff;
				sync_pkg::ADDR_LOCK_STAT:  o_rdata <= {lost_ff, locked_ff, 6'h00};
				sync_pkg::ADDR_PHASE_RB:   o_rdata <= avg_phase_ff;
				sync_pkg::ADDR_IRQ_ENABLE: o_rdata <= {irq_en_ff, 6'h00};
				default:                   o_rdata <= 8'h00;
			endcase
		end else
			o_rdata <= 8'h00;
	end
endmodule // multichip_dac_sync_logic

//--- sync_pkg.sv
// Constants for the multichip sync logic
package sync_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE_CTRL  = 8'h10;
	localparam logic [7:0] ADDR_PHASE_REQ  = 8'h11;
	localparam logic [7:0] ADDR_LOCK_STAT  = 8'h12;
	localparam logic [7:0] ADDR_PHASE_RB   = 8'h13;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int         CTRL_ENABLE_BIT = 7;
	localparam int         CTRL_DATA_BIT   = 6;
	localparam int         CTRL_EDGE_BIT   = 3;
	localparam int         STAT_LOST_BIT   = 7;
	localparam int         STAT_LOCK_BIT   = 6;
	localparam logic [7:0] MODE_CTRL_RST   = 8'h00;
	localparam logic [7:0] PHASE_REQ_RST   = 8'h00;
	localparam logic [7:0] IRQ_ENABLE_RST  = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int         NUM_STATES      = 64;
	localparam int         FIFO_DEPTH      = 8;
	localparam int         LOCK_BASE       = 11;
	localparam int         LOCK_UNIT       = 64;
	localparam logic [2:0] PHASE_THRESHOLD = 3'h1;
	// Resync load lead that covers the measure-to-reload pipeline
	localparam logic [5:0] RESYNC_LEAD     = 6'h02;
endpackage

//--- sync_chk.sv
// Checker for the multichip sync logic
`timescale 1ns/10ps
module sync_chk (
	// Clock, reset and register port
	input wire logic       i_sys_clk,
	input wire logic       i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	// Sync pins and outputs
	input wire logic       i_ref_sync_clock,
	input wire logic       i_multiplier_used,
	input wire logic       o_irq_req,
	input wire logic [5:0] o_clk_state,
	input wire logic       o_fifo_rd_strobe
);
	logic [7:0]  ctrl_ff;
	logic [7:0]  req_ff;
	logic [7:0]  ien_ff;
	logic [11:0] on_ff;
	// ------------------------------------------------------------
	// Shadows of the written registers and time since enable
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ctrl_ff <= 8'h00;
			req_ff <= 8'h00;
			ien_ff <= 8'h00;
		end else if (i_wr) begin
			if (i_addr == 8'h10) ctrl_ff <= i_wdata;
			if (i_addr == 8'h11) req_ff <= i_wdata;
			if (i_addr == 8'h14) ien_ff <= i_wdata;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n || !ctrl_ff[7]) on_ff <= 12'h000;
		else if (on_ff != 12'hfff) on_ff <= on_ff + 12'h001;
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_state_step: assert property ($past(i_rst_n) && $past(i_rst_n, 2) |->
		o_clk_state == $past(o_clk_state) + 6'h01 ||
		o_clk_state == 6'(req_ff[5:0] + sync_pkg::RESYNC_LEAD)) else $error("state step");
	a_strobe_single: assert property (o_fifo_rd_strobe |=> !o_fifo_rd_strobe)
		else $error("fifo strobe too long");
	a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
	a_status_low: assert property ($past(i_rd) && $past(i_addr) == 8'h12 |-> o_rdata[5:0] == 6'h00)
		else $error("status low bits set");
	a_frac_zero: assert property ($past(i_rd) && $past(i_addr) == 8'h13 && $past(ctrl_ff[2:0]) == 3'h0
		&& $past(ctrl_ff[2:0], 2) == 3'h0 |-> o_rdata[1:0] == 2'b00) else $error("fraction not zero");
	a_lock_enable: assert property ($past(i_rd) && $past(i_addr) == 8'h12 && !$past(ctrl_ff[7])
		&& !$past(ctrl_ff[7], 2) |-> !o_rdata[6]) else $error("locked while disabled");
	a_irq_masked: assert property ($past(ien_ff[7:6]) == 2'b00 && ien_ff[7:6] == 2'b00 |-> !o_irq_req)
		else $error("irq while masked");
	a_lock_time: assert property ($past(i_rd) && $past(i_addr) == 8'h12 && o_rdata[6]
		|-> $past(on_ff) >= 12'h2c0) else $error("lock too early");
	cover property (o_irq_req);
	cover property ($past(i_rd) && $past(i_addr) == 8'h12 && o_rdata[7]);
	cover property ($past(i_rd) && $past(i_addr) == 8'h12 && o_rdata[6]);
endmodule // sync_chk
bind multichip_dac_sync_logic sync_chk sync_chk_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ref_sync_clock(i_ref_sync_clock),
	.i_multiplier_used(i_multiplier_used), .o_irq_req(o_irq_req), .o_clk_state(o_clk_state),
	.o_fifo_rd_strobe(o_fifo_rd_strobe));

//--- ref_src.sv
// Reference sync clock source on the data source side
`timescale 1ns/10ps
module ref_src (
	// Clock and control
	input  wire logic       i_sys_clk,
	input  wire logic       i_run,
	input  wire logic [5:0] i_shift,
	// Reference out
	output logic            o_ref
);
	logic [5:0] cnt_ff = 6'h00;
	// Period of 64 sample clocks; a shift moves its phase
	always_ff @(posedge i_sys_clk) cnt_ff <= cnt_ff + 6'h01;
	// Stands low while stopped
	assign o_ref = i_run && (cnt_ff + i_shift) < 6'h20;
endmodule // ref_src

//--- tb_multichip_dac_sync_logic.sv
// Testbench for the multichip sync logic
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_multichip_dac_sync_logic;
	logic       i_sys_clk = 1'b0;
	logic       i_rst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic       i_wr = 1'b0;
	logic       i_rd = 1'b0;
	logic       run = 1'b0;
	logic       frame = 1'b0;
	logic [5:0] shift = 6'h00;
	logic       ref_clk;
	logic [7:0] o_rdata;
	logic       o_irq_req;
	logic [5:0] o_clk_state;
	logic       o_fifo_rd_strobe;
	logic [7:0] rv;
	int         failures = 0;
	int         cmp_count = 0;
	int         t0;
	int         t3;
	always #4 i_sys_clk = ~i_sys_clk;
	multichip_dac_sync_logic multichip_dac_sync_logic_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_ref_sync_clock(ref_clk), .i_multiplier_used(1'b0), .o_irq_req(o_irq_req),
		.o_clk_state(o_clk_state), .o_fifo_rd_strobe(o_fifo_rd_strobe));
	ref_src ref_src_i (.i_sys_clk(i_sys_clk), .i_run(run), .i_shift(shift), .o_ref(ref_clk));
	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 rv = o_rdata;
	endtask
	task automatic wait_lock(output int n);
		n = 0;
		rv = 8'h00;
		while (rv[6] !== 1'b1 && n < 20000) begin
			rd(8'h12);
			n += 2;
		end
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rd(8'h10); `CHK("ctrl reset", 8'h00, rv)
		wr(8'h10, 8'h4b);
		rd(8'h10); `CHK("ctrl", 8'h4b, rv)
		wr(8'h10, 8'h00);
		wr(8'h11, 8'h25);
		rd(8'h11); `CHK("request", 8'h25, rv)
		rd(8'h20); `CHK("unmapped", 8'h00, rv)
	endtask
	task automatic t_data_lock;
		wr(8'h11, 8'h05);
		wr(8'h10, 8'hc0);
		wait_lock(t0);
		`CHK("flags", 2'b01, rv[7:6])
		`CHK("lock time", 1'b1, (t0 >= 704 && t0 <= 1536))
		rd(8'h13); `CHK("quarters", 2'b00, rv[1:0])
		frame <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		frame <= 1'b0;
	endtask
	task automatic t_lost;
		wr(8'h14, 8'h80);
		@(posedge i_sys_clk) shift <= 6'h10;
		repeat (400) @(posedge i_sys_clk);
		rd(8'h12); `CHK("lost", 1'b1, rv[7])
		`CHK("irq", 1'b1, o_irq_req)
		rd(8'h12); `CHK("lost held", 1'b1, rv[7])
		wr(8'h12, 8'h00);
		rd(8'h12); `CHK("lost clear", 1'b0, rv[7])
		`CHK("irq clear", 1'b0, o_irq_req)
	endtask
	task automatic t_fifo;
		wr(8'h10, 8'h00);
		wr(8'h11, 8'h10);
		wr(8'h10, 8'h80);
		wait_lock(t0);
		`CHK("fifo lock", 1'b1, rv[6])
		frame <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		frame <= 1'b0;
		wr(8'h10, 8'h00);
		rd(8'h12); `CHK("unlocked", 1'b0, rv[6])
		wr(8'h10, 8'h8b);
		wait_lock(t3);
		`CHK("avg lock", 1'b1, rv[6])
		`CHK("slower", 1'b1, (t3 > t0))
		`CHK("avg lock time", 1'b1, (t3 >= 1216 && t3 <= 2432))
		wr(8'h14, 8'h40);
		repeat (2) @(posedge i_sys_clk);
		`CHK("lock irq", 1'b1, o_irq_req)
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		run <= 1'b1;
		t_regs;
		t_data_lock;
		t_lost;
		t_fifo;
		conclude;
	end
	initial begin
		#200000;
		failures++;
		conclude;
	end
endmodule // tb_multichip_dac_sync_logic
